// [slsp_pkg.sv]
// package: constants, register map and mode codes for the lane sample packer
// Function
// - 12-bit single channel, 6 lanes: even samples first group, odd second
// - 12-bit dual channel, 6 lanes: four A samples first group, B second
// - 8-bit single, 4 lanes: samples 0,2 first group; 1,3 second group
// - 8-bit dual, 4 lanes: A samples on first group, B on second
// - 15-bit dual decimate-by-4: AI, AQ, BI, BQ each with over-range bit
// - 15-bit single decimate-by-8, 2 lanes: I on first, Q on second
// - 15-bit dual decimate-by-8: four octets per lane, I then Q
// - 15-bit dual decimate-by-16: same four-octet layout as decimate-by-8
// - only 12-bit check offered; no 3-bit check variant
// - sync header mode setting selects check or error correction
// - bind control routes one channel to both down-converters
// - bind routes one channel to both links, except single-channel modes
// - unused channel may power down without affecting bound channel
// - whole device powers down by pin or mode field; per-channel control
// - serial output drivers disabled while power-down pin is high
// - after power-down the link must be re-established
// - selectable test patterns replace converted samples
package slsp_pkg;
  // register byte offsets
  localparam logic [7:0] SLSP_REG_MODE = 8'h00;
  localparam logic [7:0] SLSP_REG_ROUTE = 8'h04;
  localparam logic [7:0] SLSP_REG_PWR = 8'h08;
  localparam logic [7:0] SLSP_REG_STAT = 8'h0C;
  // link mode codes
  localparam logic [3:0] SLSP_M_S12 = 4'h0;
  localparam logic [3:0] SLSP_M_D12 = 4'h1;
  localparam logic [3:0] SLSP_M_S8 = 4'h2;
  localparam logic [3:0] SLSP_M_D8 = 4'h3;
  localparam logic [3:0] SLSP_M_D15D4 = 4'h4;
  localparam logic [3:0] SLSP_M_S15D8 = 4'h5;
  localparam logic [3:0] SLSP_M_D15D8 = 4'h6;
  localparam logic [3:0] SLSP_M_D15D16 = 4'h7;
  // field positions
  localparam int SLSP_F_SHMODE = 4;
  localparam int SLSP_F_TEST = 8;
  localparam int SLSP_F_DEVPD = 12;
  localparam int SLSP_F_BINDA = 0;
  localparam int SLSP_F_BINDB = 1;
  localparam int SLSP_F_PDA = 0;
  localparam int SLSP_F_PDB = 1;
  localparam logic [31:0] SLSP_MODE_RST = 32'h0000_0000;
  localparam logic [1:0] SLSP_RESP_OK = 2'h0;
  localparam logic [1:0] SLSP_RESP_SLVERR = 2'h2;
  localparam logic [15:0] SLSP_TP_WORD = 16'hA5C3;
  localparam int SLSP_LANES = 6;
  localparam int SLSP_LW = 32;
  typedef logic [SLSP_LW-1:0] slsp_lane_t;
endpackage : slsp_pkg

// [slsp_lane_if.sv]
// interface: packed lane words passed from the packer to the top
`timescale 1ns/100ps
interface slsp_lane_if;
  logic [31:0] lane [6];
  logic [5:0] laneEn;
  modport src (output lane, output laneEn);
  modport dst (input lane, input laneEn);
endinterface : slsp_lane_if

// [slsp_packer.sv]
// module: combinational sample-to-lane packer for every supported link mode
`timescale 1ns/100ps
module slsp_packer
  import slsp_pkg::*;
(
  input wire logic [3:0] linkMode, // link_mode_select
  input wire logic [3:0] testSel, // nonzero inserts pattern
  input wire logic [47:0] smpA, // four 12-bit channel A samples, 0 at msb
  input wire logic [47:0] smpB, // four 12-bit channel B samples
  input wire logic [15:0] iqA, // spare, unused by every supported mode
  input wire logic [31:0] cplxA, // {AI[14:0],chan_a_inphase_overrange,AQ[14:0],chan_a_quad_overrange}
  input wire logic [31:0] cplxB, // {BI[14:0],chan_b_inphase_overrange,BQ[14:0],chan_b_quad_overrange}
  slsp_lane_if.src lo // packed lanes
);
  // 12-bit nibble packing of samples p,q,r,s over 3 lanes of two octets
  function automatic logic [47:0] pack12(input logic [47:0] s);
    pack12 = s;
  endfunction : pack12

  // mode decode; 15-bit words sit with the msb first in octet 0
  always_comb
  begin
    logic [47:0] ga;
    logic [47:0] gb;
    ga = '0;
    gb = '0;
    for (int k = 0; k < 6; k++) lo.lane[k] = '0;
    lo.laneEn = 6'h00;
    case (linkMode)
      SLSP_M_S12:
      begin
        // single mode: convA holds the even samples, convB the odd ones
        ga = pack12(smpA);
        gb = pack12(smpB);
        lo.laneEn = 6'h3F;
      end
      SLSP_M_D12:
      begin
        ga = pack12(smpA);
        gb = pack12(smpB);
        lo.laneEn = 6'h3F;
      end
      SLSP_M_S8:
      begin
        ga = {smpA[47:40], 8'h00, smpA[35:28], 8'h00, 16'h0000};
        gb = {smpB[47:40], 8'h00, smpB[35:28], 8'h00, 16'h0000};
        lo.laneEn = 6'h1B;
      end
      SLSP_M_D8:
      begin
        ga = {smpA[47:40], 8'h00, smpA[35:28], 8'h00, 16'h0000};
        gb = {smpB[47:40], 8'h00, smpB[35:28], 8'h00, 16'h0000};
        lo.laneEn = 6'h1B;
      end
      SLSP_M_D15D4:
      begin
        ga = {cplxA[31:16], cplxA[15:0], 16'h0000};
        gb = {cplxB[31:16], cplxB[15:0], 16'h0000};
        lo.laneEn = 6'h1B;
      end
      SLSP_M_S15D8:
      begin
        ga = {cplxA[31:16], 32'h0000_0000};
        gb = {cplxA[15:0], 32'h0000_0000};
        lo.laneEn = 6'h09;
      end
      SLSP_M_D15D8, SLSP_M_D15D16:
      begin
        ga = {cplxA, 16'h0000};
        gb = {cplxB, 16'h0000};
        lo.laneEn = 6'h09;
      end
      default:
      begin
        ga = '0;
        gb = '0;
      end
    endcase
    // lanes 0..2 first group, 3..5 second; wide modes use 32-bit lane 0/3
    if (linkMode == SLSP_M_D15D8 || linkMode == SLSP_M_D15D16)
    begin
      lo.lane[0] = ga[47:16];
      lo.lane[3] = gb[47:16];
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        lo.lane[k] = {ga[47-16*k -: 16], 16'h0000};
        lo.lane[k+3] = {gb[47-16*k -: 16], 16'h0000};
      end
    end
    // test pattern replaces converted samples on every lane
    if (testSel != 4'h0)
      for (int k = 0; k < 6; k++)
        lo.lane[k] = {SLSP_TP_WORD, 12'h000, testSel};
  end
endmodule : slsp_packer

// [slsp_top.sv]
// module: lane sample packer with AXI4-Lite registers and power control
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module slsp_top
  import slsp_pkg::*;
(
  input wire logic clk_sys, // 40 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic powerdownPin, // powerdown_pin
  input wire logic smpValid, // one sample set per cycle
  input wire logic [47:0] convA, // channel A four 12-bit samples
  input wire logic [47:0] convB, // channel B four 12-bit samples
  input wire logic [31:0] ddcA, // down-converter A {I,or,Q,or}
  input wire logic [31:0] ddcB, // down-converter B {I,or,Q,or}
  input wire logic linkUp, // link re-established by link layer
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [191:0] laneData, // six 32-bit lanes, lane 0 at top
  output logic [5:0] laneDrvEn, // per-lane driver enable
  output logic laneValid, // lane data valid
  output logic crcSel, // sync header uses 12-bit check
  output logic fecSel, // sync header uses error correction
  output logic chanAPwrDn, // chan_a_powerdown to converter
  output logic chanBPwrDn, // chan_b_powerdown to converter
  output logic devPwrDn // whole device powered down
);
  logic [31:0] mode_r, mode_nxt;
  logic [31:0] route_r, route_nxt;
  logic [31:0] pwr_r, pwr_nxt;
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
  logic [7:0] awA_r, awA_nxt;
  logic [31:0] wD_r, wD_nxt;
  logic [3:0] wS_r, wS_nxt;
  logic bV_r, bV_nxt, rV_r, rV_nxt;
  logic [1:0] bR_r, bR_nxt, rR_r, rR_nxt;
  logic [31:0] rD_r, rD_nxt;
  logic [191:0] lane_r, lane_nxt;
  logic [5:0] drv_r, drv_nxt;
  logic lv_r, lv_nxt;
  logic pdAll;
  logic [3:0] linkMode;
  logic [31:0] selA, selB;
  logic [47:0] rawA, rawB;
  slsp_lane_if lif ();

  // one register word covers a known offset
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == SLSP_REG_MODE) || (a == SLSP_REG_ROUTE) ||
      (a == SLSP_REG_PWR) || (a == SLSP_REG_STAT);
  endfunction : isMapped

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      o[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
    merge = o;
  endfunction : merge

  assign linkMode = mode_r[3:0];
  // pin or mode field powers the whole device down
  assign pdAll = powerdownPin | mode_r[SLSP_F_DEVPD];

  // bind selects one converter's data for both paths; single modes exempt
  always_comb
  begin
    logic single;
    single = (linkMode == SLSP_M_S12) || (linkMode == SLSP_M_S8) ||
      (linkMode == SLSP_M_S15D8);
    rawA = convA;
    rawB = convB;
    selA = ddcA;
    selB = ddcB;
    if (!single && route_r[SLSP_F_BINDA])
    begin
      rawB = convA;
      selB = ddcA;
    end
    else if (!single && route_r[SLSP_F_BINDB])
    begin
      rawA = convB;
      selA = ddcB;
    end
  end

  slsp_packer u_pack (
    .linkMode(linkMode),
    .testSel(mode_r[SLSP_F_TEST +: 4]),
    .smpA(rawA),
    .smpB(rawB),
    .iqA(16'h0000),
    .cplxA(selA),
    .cplxB(selB),
    .lo(lif.src)
  );

  // register write and read channels; awready/wready high while free
  always_comb
  begin
    logic [31:0] stat;
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awA_nxt = awA_r;
    wD_nxt = wD_r;
    wS_nxt = wS_r;
    bV_nxt = bV_r;
    bR_nxt = bR_r;
    rV_nxt = rV_r;
    rR_nxt = rR_r;
    rD_nxt = rD_r;
    mode_nxt = mode_r;
    route_nxt = route_r;
    pwr_nxt = pwr_r;
    stat = {26'h0, linkUp, lv_r, pdAll, chanBPwrDn, chanAPwrDn, 1'b0};
    // take only while ready is shown, so nothing slips in under reset
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHave_nxt = 1'b1;
      awA_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHave_nxt = 1'b1;
      wD_nxt = s_axi_wdata;
      wS_nxt = s_axi_wstrb;
    end
    if (awHave_r && wHave_r)
    begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bV_nxt = 1'b1;
      bR_nxt = isMapped(awA_r) ? SLSP_RESP_OK : SLSP_RESP_SLVERR;
      case (awA_r)
        SLSP_REG_MODE: mode_nxt = merge(mode_r, wD_r, wS_r);
        SLSP_REG_ROUTE: route_nxt = merge(route_r, wD_r, wS_r);
        SLSP_REG_PWR: pwr_nxt = merge(pwr_r, wD_r, wS_r);
        default: mode_nxt = mode_r;
      endcase
    end
    if (bV_r && s_axi_bready)
      bV_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rV_nxt = 1'b1;
      rR_nxt = isMapped(s_axi_araddr) ? SLSP_RESP_OK : SLSP_RESP_SLVERR;
      case (s_axi_araddr)
        SLSP_REG_MODE: rD_nxt = mode_r;
        SLSP_REG_ROUTE: rD_nxt = route_r;
        SLSP_REG_PWR: rD_nxt = pwr_r;
        SLSP_REG_STAT: rD_nxt = stat;
        default: rD_nxt = 32'h0000_0000;
      endcase
    end
    else if (rV_r && s_axi_rready)
      rV_nxt = 1'b0;
  end

  // lane stage; power-down blanks drivers and data, lane valid then waits until link is back
  always_comb
  begin
    lane_nxt = lane_r;
    drv_nxt = lif.laneEn;
    lv_nxt = lv_r;
    if (pdAll)
    begin
      drv_nxt = 6'h00;
      lane_nxt = '0;
      lv_nxt = 1'b0;
    end
    else
    begin
      if (smpValid)
        for (int k = 0; k < SLSP_LANES; k++)
          lane_nxt[191-32*k -: 32] = lif.lane[k];
      lv_nxt = smpValid & linkUp;
    end
  end

  // register stage
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= SLSP_MODE_RST;
      route_r <= '0;
      pwr_r <= '0;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awA_r <= '0;
      wD_r <= '0;
      wS_r <= '0;
      bV_r <= 1'b0;
      bR_r <= '0;
      rV_r <= 1'b0;
      rR_r <= '0;
      rD_r <= '0;
      lane_r <= '0;
      drv_r <= '0;
      lv_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      crcSel <= 1'b1;
      fecSel <= 1'b0;
      chanAPwrDn <= 1'b0;
      chanBPwrDn <= 1'b0;
      devPwrDn <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      route_r <= route_nxt;
      pwr_r <= pwr_nxt;
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awA_r <= awA_nxt;
      wD_r <= wD_nxt;
      wS_r <= wS_nxt;
      bV_r <= bV_nxt;
      bR_r <= bR_nxt;
      rV_r <= rV_nxt;
      rR_r <= rR_nxt;
      rD_r <= rD_nxt;
      lane_r <= lane_nxt;
      drv_r <= drv_nxt;
      lv_r <= lv_nxt;
      s_axi_awready <= !awHave_nxt && !bV_nxt;
      s_axi_wready <= !wHave_nxt && !bV_nxt;
      s_axi_arready <= !rV_nxt;
      // only the 12-bit check exists; bit clear means check, set means fec
      crcSel <= !mode_nxt[SLSP_F_SHMODE];
      fecSel <= mode_nxt[SLSP_F_SHMODE];
      chanAPwrDn <= pdAll | pwr_nxt[SLSP_F_PDA];
      chanBPwrDn <= pdAll | pwr_nxt[SLSP_F_PDB];
      devPwrDn <= pdAll;
    end
  end

  assign s_axi_bvalid = bV_r;
  assign s_axi_bresp = bR_r;
  assign s_axi_rvalid = rV_r;
  assign s_axi_rresp = rR_r;
  assign s_axi_rdata = rD_r;
  assign laneData = lane_r;
  assign laneDrvEn = drv_r;
  assign laneValid = lv_r;
endmodule : slsp_top

// [slsp_chk_sva.sv]
// checker: port properties of the lane sample packer
`timescale 1ns/100ps
module slsp_chk (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic powerdownPin, // pin
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready, // r
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [5:0] laneDrvEn, // drivers
  input wire logic laneValid, // valid
  input wire logic crcSel, // crc
  input wire logic fecSel, // fec
  input wire logic devPwrDn // device off
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // a pin held over two edges has reached the lane drivers, lane valid and device power-down
  drv_off_a: assert property (powerdownPin[*2] |-> !laneDrvEn)
    else $error("drivers on in powerdown");
  dev_off_a: assert property (powerdownPin[*2] |-> devPwrDn)
    else $error("device not off");
  no_valid_a: assert property (powerdownPin[*2] |-> !laneValid)
    else $error("lane valid in powerdown");
  hdr_one_a: assert property (crcSel != fecSel)
    else $error("sync header mode");
  lane_mask_a: assert property (laneValid |->
    laneDrvEn inside {6'h3F, 6'h1B, 6'h09})
    else $error("bad lane mask");
  // a read answer comes the cycle after its address; register answers stand until the master takes them
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("late read answer");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid)
    else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid)
    else $error("write answer dropped");
  cover property (laneValid && laneDrvEn == 6'h09);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (powerdownPin[*2]);
endmodule : slsp_chk
bind slsp_top slsp_chk chk_u (.*);

// [slsp_rx_model.sv]
// partner: link receiver that locks again after the lanes return
`timescale 1ns/100ps
module slsp_rx_model #(
  parameter int LOCK_CYC = 8 // frames discarded before lock
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic [5:0] laneDrvEn, // lane drivers
  output logic linkUp // link established
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  // stale pipeline data is thrown away, so lock waits a while
  always_comb
  begin
    cnt_nxt = cnt_r;
    // lock follows driven lanes; lane valid waits on lock, so not on it
    if (laneDrvEn == 6'h00)
      cnt_nxt = 8'h00;
    else if (cnt_r != LOCK_CYC[7:0])
      cnt_nxt = cnt_r + 8'h01;
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end
  assign linkUp = (cnt_r == LOCK_CYC[7:0]);
endmodule : slsp_rx_model

// [testbench.sv]
// testbench: register, packing and power-down scenarios
`timescale 1ns/100ps
module testbench;
  import slsp_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, powerdownPin = 1'b0, smpValid = 1'b1;
  logic [47:0] convA = 48'h1234_5678_9ABC, convB = 48'hFEDC_BA98_7654;
  logic [31:0] ddcA = 32'h1357_9BDF, ddcB = 32'h2468_ACE0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, linkUp, laneValid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, crcSel, fecSel, chanAPwrDn, chanBPwrDn, devPwrDn;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [191:0] laneData;
  logic [5:0] laneDrvEn;
  int error_cnt = 0;
  int checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  slsp_top dut_u (.*);
  slsp_rx_model rx_u (.*);
  task automatic chk(input logic [191:0] got, exp, input string m);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  // bready stands from the request until the answer is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    {rd, rsp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rdr
  // {lane mask, lane word} expected on lane k; ba routes convA to both groups, not ddcA
  function automatic logic [63:0] ex(logic [3:0] m, int k, logic ba);
    logic [47:0] s;
    logic [31:0] d;
    int j;
    s = (k < 3 || ba) ? convA : convB;
    d = (k < 3) ? ddcA : ddcB;
    j = k % 3;
    case (m)
      SLSP_M_S12, SLSP_M_D12:
        return {32'hFFFF0000, s[47-16*j -: 16], 16'h0};
      SLSP_M_S8, SLSP_M_D8: if (j < 2)
        return {32'hFF000000, s[47-12*j -: 8], 24'h0};
      SLSP_M_D15D4: if (j < 2)
        return {32'hFFFF0000, d[31-16*j -: 16], 16'h0};
      SLSP_M_S15D8: if (j == 0)
        return {32'hFFFF0000, ddcA[31-16*(k/3) -: 16], 16'h0};
      default: if (j == 0) return {32'hFFFFFFFF, d};
    endcase
    return 64'h0;
  endfunction : ex
  task automatic cmp(input logic [3:0] m, input logic ba);
    logic [63:0] x;
    logic [5:0] en;
    en = '0;
    for (int k = 0; k < 6; k++)
    begin
      x = ex(m, k, ba);
      en[k] = |x[63:32];
      chk(laneData[191-32*k -: 32] & x[63:32], x[31:0], "lane");
    end
    chk(laneDrvEn, en, "lane enables");
  endtask : cmp
  task automatic t_regs;
    rdr(SLSP_REG_MODE);
    chk(rd, SLSP_MODE_RST, "mode reset");
    chk({crcSel, fecSel}, 2'b10, "crc at reset");
    wr(SLSP_REG_MODE, 32'h10);
    chk({crcSel, fecSel}, 2'b01, "fec select");
    rdr(8'h20);
    chk({rsp, rd}, {SLSP_RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h10, 32'hFFFF_FFFF);
    chk(rsp, SLSP_RESP_SLVERR, "unmapped write");
  endtask : t_regs
  task automatic t_pack;
    logic [3:0] md [8];
    md = '{SLSP_M_S12, SLSP_M_D12, SLSP_M_S8, SLSP_M_D8, SLSP_M_D15D4,
      SLSP_M_S15D8, SLSP_M_D15D8, SLSP_M_D15D16};
    foreach (md[i])
    begin
      wr(SLSP_REG_MODE, {28'h0, md[i]});
      repeat (2) @(posedge clk_sys);
      cmp(md[i], 1'b0);
    end
  endtask : t_pack
  // channel A feeds both links while channel B sleeps, then channel B feeds both
  task automatic t_bind;
    wr(SLSP_REG_MODE, {28'h0, SLSP_M_D12});
    wr(SLSP_REG_ROUTE, 32'h1);
    wr(SLSP_REG_PWR, 32'h2);
    repeat (2) @(posedge clk_sys);
    cmp(SLSP_M_D12, 1'b1);
    chk({chanAPwrDn, chanBPwrDn}, 2'b01, "chan b off");
    wr(SLSP_REG_ROUTE, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(laneData[191:176], convB[47:32], "b on both");
    // single modes ignore the bind and keep their own layout
    wr(SLSP_REG_MODE, {28'h0, SLSP_M_S12});
    wr(SLSP_REG_ROUTE, 32'h1);
    repeat (2) @(posedge clk_sys);
    cmp(SLSP_M_S12, 1'b0);
    wr(SLSP_REG_ROUTE, 32'h0);
    wr(SLSP_REG_PWR, 32'h0);
    wr(SLSP_REG_MODE, 32'h100);
    repeat (2) @(posedge clk_sys);
    chk(laneData[191:176], SLSP_TP_WORD, "test word");
  endtask : t_bind
  task automatic t_pwr;
    wr(SLSP_REG_MODE, 32'h1000);
    chk(devPwrDn, 1'b1, "mode powerdown");
    wr(SLSP_REG_MODE, 32'h0);
    // no calibration runs here, so no converter-off setting is needed
    powerdownPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({laneDrvEn, devPwrDn}, 7'h01, "pin powerdown");
    chk(laneValid, 1'b0, "no valid in powerdown");
    rdr(SLSP_REG_STAT);
    chk(rd[5], 1'b0, "link down");
    powerdownPin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(laneValid, 1'b0, "held until lock");
    repeat (17) @(posedge clk_sys);
    rdr(SLSP_REG_STAT);
    chk(rd[5], 1'b1, "link back");
    chk(laneValid, 1'b1, "valid after lock");
  endtask : t_pwr
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs;
    t_pack;
    t_bind;
    t_pwr;
    tally_and_finish;
  end
  // the run needs some 150 cycles; over a hundred times that is a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish;
  end
endmodule : testbench
